// ### rcps_params.svh
`ifndef RCPS_PARAMS_SVH
`define RCPS_PARAMS_SVH
// indirect type codes for the registers held here
`define RCPS_TYPE_PARAMS 4'h6
`define RCPS_TYPE_SECONDARY 4'h7
`define RCPS_TYPE_STATE 4'hE
// command source instances
`define RCPS_CMD_INST_A 3'h6
`define RCPS_CMD_INST_B 3'h7
`define RCPS_NUM_RINGS 6
`define RCPS_NUM_CHAN 8
// field positions, shared by ring, command and secondary layouts
`define RCPS_BIT_RING_PAR 7
`define RCPS_BIT_DATA_PAR 6
`define RCPS_BIT_RING_PORT 5
`define RCPS_BIT_DATA_PORT 4
`define RCPS_SIZE_MSB 3
`define RCPS_LSIZE_MSB 2
// ring state bit positions
`define RCPS_ST_PRESENT 7
`define RCPS_ST_PARITY 6
`define RCPS_ST_OPERR 5
`define RCPS_ST_DRDY 4
`define RCPS_ST_STOP 3
`define RCPS_ST_READY 2
`define RCPS_ST_EMPTY 1
`define RCPS_ST_CPL 0
// writable masks, the state read mask for rings 6 and 7, and reset values
`define RCPS_CMD_MASK 8'h50
`define RCPS_SEC_DEST_MASK 8'hBF
`define RCPS_SEC_LOCAL_MASK 8'h57
`define RCPS_RESET_BYTE 8'h00
`define RCPS_DRDY_ONLY 8'h10
// sizes: ring 8 bytes << code, local 8k bytes << code
`define RCPS_RING_BASE_BYTES 32'h0000_0008
`define RCPS_LOCAL_BASE_BYTES 32'h0000_2000
`define RCPS_STEP_32 32'h0000_0004
`define RCPS_STEP_64 32'h0000_0008
`endif

// ### rcps_pkg.sv
package rcps_pkg;
  typedef enum logic [2:0] {
    RCPS_ST_ABSENT = 3'b000,
    RCPS_ST_RDY = 3'b001,
    RCPS_ST_STP = 3'b010,
    RCPS_ST_EMP = 3'b011,
    RCPS_ST_CMP = 3'b100
  } rcps_ring_state_t;
  typedef logic [7:0] rcps_byte_t;
endpackage

// ### rcps_cfg_if.sv
`timescale 1ns/1ps
// write strobe and read path between the top and the register bank
interface rcps_cfg_if;
  logic wr_en;
  logic [3:0] type_idx;
  logic [2:0] inst_idx;
  logic [7:0] wr_data;
  logic local_mode_sel;
  logic [7:0] rd_data;
  logic [63:0] ring_bank;
  logic [63:0] sec_bank;
  logic [15:0] cmd_bank;
  modport master (output wr_en, type_idx, inst_idx, wr_data, local_mode_sel,
    input rd_data, ring_bank, sec_bank, cmd_bank);
  modport bank (input wr_en, type_idx, inst_idx, wr_data, local_mode_sel,
    output rd_data, ring_bank, sec_bank, cmd_bank);
endinterface

// ### rcps_param_bank.sv
`timescale 1ns/1ps
`include "rcps_params.svh"
// holds command source, ring and secondary parameter bytes
module rcps_param_bank (
  input wire logic core_clk,
  input wire logic nrst,
  rcps_cfg_if.bank cfg
);
  import rcps_pkg::*;
  logic [7:0] ring_reg [0:7];
  logic [7:0] sec_reg [0:7];
  logic [7:0] rd_reg;
  logic [2:0] ri;

  assign ri = cfg.inst_idx;

  // parameter writes; unused bits stay zero via masks
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < `RCPS_NUM_CHAN; i++) begin
        ring_reg[i] <= `RCPS_RESET_BYTE;
        sec_reg[i] <= `RCPS_RESET_BYTE;
      end
    end else if (cfg.wr_en) begin
      if (cfg.type_idx == `RCPS_TYPE_PARAMS) begin
        if (ri == `RCPS_CMD_INST_A || ri == `RCPS_CMD_INST_B) begin
          ring_reg[ri] <= cfg.wr_data & `RCPS_CMD_MASK;
        end else begin
          ring_reg[ri] <= cfg.wr_data;
        end
      end
      if (cfg.type_idx == `RCPS_TYPE_SECONDARY) begin
        // local layout only applies to channels 0-5
        if (cfg.local_mode_sel && ri < 3'(`RCPS_NUM_RINGS)) begin
          sec_reg[ri] <= cfg.wr_data & `RCPS_SEC_LOCAL_MASK;
        end else begin
          sec_reg[ri] <= cfg.wr_data & `RCPS_SEC_DEST_MASK;
        end
      end
    end
  end

  // registered read data
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rd_reg <= `RCPS_RESET_BYTE;
    end else if (cfg.type_idx == `RCPS_TYPE_SECONDARY) begin
      rd_reg <= sec_reg[ri];
    end else begin
      rd_reg <= ring_reg[ri];
    end
  end

  assign cfg.rd_data = rd_reg;
  for (genvar g = 0; g < 8; g++) begin : g_flat
    assign cfg.ring_bank[g*8 +: 8] = ring_reg[g];
    assign cfg.sec_bank[g*8 +: 8] = sec_reg[g];
  end
  assign cfg.cmd_bank = {ring_reg[7], ring_reg[6]};
endmodule

// ### rcps_top.sv
`timescale 1ns/1ps
`include "rcps_params.svh"
// How it works
// - direct transmit command data uses port B when its select bit set
// - command data parity checked when its enable bit set
// - six ring parameter registers; ring parity enable checks entry reads
// - ring data parity enable checks all data of that ring
// - ring entries use port B when entry select set, else A
// - ring data use port B when data select set, else A
// - ring size code gives 8 bytes shifted left by code
// - address advances by transfer width, wraps inside size-aligned region
// - eight secondary registers: destination ring or local memory layout
// - destination ring data use port B when its select set
// - local memory parity checked when local enable set
// - local memory uses port B when local select set
// - local size is 8K doubled per code step
// - local start address comes from define-local-memory command
// - eight state registers; rings 6,7 hold only destination ready
// - present bit cleared means ring absent
// - parity fault set on entry read error, cleared on redefine or ready
// - op error set on entry read error, cleared on redefine or ready
// - destination ready bit shows destination ring ready
// - state bits encode ready, stop, empty, complete
// - ready and complete may coexist; read errors leave empty set
// - 8-bit registers reached through type and instance indices
// - parity odd when port A parity control 0, even when 1
// - 64-bit mode: port A control governs, A carries upper half
module rcps_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ind_wr,
  input wire logic ind_rd,
  input wire logic [3:0] indirect_type_index,
  input wire logic [2:0] indirect_instance_index,
  input wire logic [7:0] ind_wdata,
  output rcps_pkg::rcps_byte_t ind_rdata,
  output logic ind_rvalid,
  input wire logic parity_even_sel,
  input wire logic wide_mode,
  input wire logic [7:0] local_mode,
  input wire logic [7:0] ring_define,
  input wire logic [7:0] ring_ready_access,
  input wire logic [7:0] ring_stop_evt,
  input wire logic [7:0] ring_empty_evt,
  input wire logic [7:0] ring_complete_evt,
  input wire logic [7:0] entry_read_done,
  input wire logic [7:0] entry_parity_err,
  input wire logic [7:0] entry_op_err,
  input wire logic [7:0] dest_ready_set,
  input wire logic [7:0] dest_ready_clr,
  input wire logic [7:0] ring_remove,
  input wire logic [2:0] addr_chan,
  input wire logic addr_load,
  input wire logic [31:0] addr_load_val,
  input wire logic addr_step,
  input wire logic [2:0] xfer_chan,
  input wire logic xfer_is_cmd,
  input wire logic [31:0] local_base_in,
  input wire logic local_base_load,
  output logic [31:0] ring_addr,
  output logic entry_port_b,
  output logic entry_par_chk,
  output logic data_port_b,
  output logic data_par_chk,
  output logic dest_data_port_b,
  output logic local_port_b,
  output logic local_par_chk,
  output logic [31:0] local_base,
  output logic [31:0] local_bytes,
  output logic parity_odd,
  output logic upper_half_a
);
  import rcps_pkg::*;

  rcps_cfg_if cfg ();
  logic [7:0] state_reg [0:7];
  rcps_ring_state_t st_reg [0:7];
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic rd_state_q;
  logic [31:0] addr_reg;
  logic [31:0] addr_next;
  logic [31:0] lbase_reg [0:5];
  logic [7:0] rp;
  logic [7:0] sp;
  logic [7:0] cp;

  // ring byte limit from four-bit code
  function automatic logic [31:0] ring_bytes(input logic [3:0] code);
    ring_bytes = `RCPS_RING_BASE_BYTES << code;
  endfunction

  // local space size from three-bit code
  function automatic logic [31:0] local_len(input logic [2:0] code);
    local_len = `RCPS_LOCAL_BASE_BYTES << code;
  endfunction

  // advance an address, wrapping inside the aligned region
  function automatic logic [31:0] ring_advance(input logic [31:0] a,
      input logic [3:0] code, input logic wide);
    logic [31:0] m;
    logic [31:0] s;
    m = ring_bytes(code) - 32'h0000_0001;
    s = a + (wide ? `RCPS_STEP_64 : `RCPS_STEP_32);
    ring_advance = (a & ~m) | (s & m);
  endfunction

  // indirect write path; registers are 8 bits wide
  assign cfg.wr_en = ind_wr;
  assign cfg.type_idx = indirect_type_index;
  assign cfg.inst_idx = indirect_instance_index;
  assign cfg.wr_data = ind_wdata;
  assign cfg.local_mode_sel = local_mode[indirect_instance_index];

  rcps_param_bank u_bank (
    .core_clk(core_clk),
    .nrst(nrst),
    .cfg(cfg)
  );

  assign rp = cfg.ring_bank[xfer_chan*8 +: 8];
  assign sp = cfg.sec_bank[xfer_chan*8 +: 8];
  assign cp = xfer_chan[0] ? cfg.cmd_bank[15:8] : cfg.cmd_bank[7:0];

  // ring state machine per ring 0-5
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < 8; i++) begin
        st_reg[i] <= RCPS_ST_ABSENT;
      end
    end else begin
      for (int i = 0; i < `RCPS_NUM_RINGS; i++) begin
        case (st_reg[i])
          RCPS_ST_ABSENT: begin
            if (ring_define[i]) begin
              st_reg[i] <= RCPS_ST_STP;
            end
          end
          default: begin
            if (ring_remove[i]) begin
              st_reg[i] <= RCPS_ST_ABSENT;
            end else if (ring_ready_access[i] || ring_define[i]) begin
              st_reg[i] <= RCPS_ST_RDY;
            end else if (entry_parity_err[i] || entry_op_err[i] || ring_empty_evt[i]) begin
              st_reg[i] <= RCPS_ST_EMP;
            end else if (ring_stop_evt[i]) begin
              st_reg[i] <= RCPS_ST_STP;
            end else if (ring_complete_evt[i]) begin
              st_reg[i] <= RCPS_ST_CMP;
            end
          end
        endcase
      end
    end
  end

  // state bytes: set wins over clear for drdy, parity and op error; a ready access outranks other ring events
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < 8; i++) begin
        state_reg[i] <= `RCPS_RESET_BYTE;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (dest_ready_set[i]) begin
          state_reg[i][`RCPS_ST_DRDY] <= 1'b1;
        end else if (dest_ready_clr[i]) begin
          state_reg[i][`RCPS_ST_DRDY] <= 1'b0;
        end
      end
      for (int i = 0; i < `RCPS_NUM_RINGS; i++) begin
        state_reg[i][`RCPS_ST_PRESENT] <= (st_reg[i] != RCPS_ST_ABSENT) && !ring_remove[i];
        if (entry_parity_err[i]) begin
          state_reg[i][`RCPS_ST_PARITY] <= 1'b1;
        end else if (ring_define[i] || ring_ready_access[i]) begin
          state_reg[i][`RCPS_ST_PARITY] <= 1'b0;
        end
        if (entry_op_err[i]) begin
          state_reg[i][`RCPS_ST_OPERR] <= 1'b1;
        end else if (ring_define[i] || ring_ready_access[i]) begin
          state_reg[i][`RCPS_ST_OPERR] <= 1'b0;
        end
        // complete stays up after a ready access until the next entry read
        if (ring_ready_access[i] || ring_define[i]) begin
          state_reg[i][`RCPS_ST_STOP] <= 1'b0;
          state_reg[i][`RCPS_ST_READY] <= 1'b1;
          state_reg[i][`RCPS_ST_EMPTY] <= 1'b0;
        end else if (entry_parity_err[i] || entry_op_err[i] || ring_empty_evt[i]) begin
          state_reg[i][`RCPS_ST_READY] <= 1'b0;
          state_reg[i][`RCPS_ST_EMPTY] <= 1'b1;
          state_reg[i][`RCPS_ST_CPL] <= 1'b0;
        end else if (ring_stop_evt[i]) begin
          state_reg[i][`RCPS_ST_STOP] <= 1'b1;
          state_reg[i][`RCPS_ST_READY] <= 1'b0;
        end else if (ring_complete_evt[i]) begin
          state_reg[i][`RCPS_ST_READY] <= 1'b0;
          state_reg[i][`RCPS_ST_CPL] <= 1'b1;
        end else if (entry_read_done[i]) begin
          state_reg[i][`RCPS_ST_CPL] <= 1'b0;
        end
      end
    end
  end

  // read response: state is read here, parameters come from the bank
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rd_state_q <= 1'b0;
      rvalid_reg <= 1'b0;
    end else begin
      rd_state_q <= ind_rd && (indirect_type_index == `RCPS_TYPE_STATE);
      rvalid_reg <= ind_rd;
    end
  end

  // rings 6 and 7 expose only destination ready
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdata_reg <= `RCPS_RESET_BYTE;
    end else if (ind_rd && indirect_type_index == `RCPS_TYPE_STATE) begin
      if (indirect_instance_index >= 3'(`RCPS_NUM_RINGS)) begin
        rdata_reg <= state_reg[indirect_instance_index] & `RCPS_DRDY_ONLY;
      end else begin
        rdata_reg <= state_reg[indirect_instance_index];
      end
    end
  end

  assign ind_rdata = rd_state_q ? rdata_reg : cfg.rd_data;
  assign ind_rvalid = rvalid_reg;

  // ring address tracking for the selected ring
  always_comb begin
    addr_next = ring_advance(addr_reg, cfg.ring_bank[addr_chan*8 +: 4], wide_mode);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      addr_reg <= 32'h0000_0000;
    end else if (addr_load) begin
      addr_reg <= addr_load_val;
    end else if (addr_step) begin
      addr_reg <= addr_next;
    end
  end

  // local base addresses come only from the define-local-memory command
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < `RCPS_NUM_RINGS; i++) begin
        lbase_reg[i] <= 32'h0000_0000;
      end
    end else if (local_base_load && xfer_chan < 3'(`RCPS_NUM_RINGS)) begin
      lbase_reg[xfer_chan] <= local_base_in;
    end
  end

  // port and parity steering; 64-bit mode forces port A, selects ignored
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ring_addr <= 32'h0000_0000;
      entry_port_b <= 1'b0;
      entry_par_chk <= 1'b0;
      data_port_b <= 1'b0;
      data_par_chk <= 1'b0;
      dest_data_port_b <= 1'b0;
      local_port_b <= 1'b0;
      local_par_chk <= 1'b0;
      local_base <= 32'h0000_0000;
      local_bytes <= 32'h0000_0000;
      parity_odd <= 1'b1;
      upper_half_a <= 1'b0;
    end else begin
      ring_addr <= addr_reg;
      parity_odd <= !parity_even_sel;
      upper_half_a <= wide_mode;
      if (xfer_is_cmd) begin
        entry_port_b <= 1'b0;
        entry_par_chk <= 1'b0;
        data_port_b <= cp[`RCPS_BIT_DATA_PORT] && !wide_mode;
        data_par_chk <= cp[`RCPS_BIT_DATA_PAR];
      end else begin
        entry_port_b <= rp[`RCPS_BIT_RING_PORT] && !wide_mode;
        entry_par_chk <= rp[`RCPS_BIT_RING_PAR];
        data_port_b <= rp[`RCPS_BIT_DATA_PORT] && !wide_mode;
        data_par_chk <= rp[`RCPS_BIT_DATA_PAR];
      end
      dest_data_port_b <= sp[`RCPS_BIT_DATA_PORT] && !wide_mode;
      local_port_b <= sp[`RCPS_BIT_DATA_PORT] && !wide_mode;
      local_par_chk <= local_mode[xfer_chan] && sp[`RCPS_BIT_DATA_PAR];
      local_bytes <= local_len(sp[`RCPS_LSIZE_MSB:0]);
      local_base <= (xfer_chan < 3'(`RCPS_NUM_RINGS)) ? lbase_reg[xfer_chan] : 32'h0000_0000;
    end
  end
endmodule

// ### rcps_props.sv
`timescale 1ns/1ps
module rcps_props (
  input logic core_clk,
  input logic nrst,
  input logic ind_rd,
  input logic [3:0] indirect_type_index,
  input logic [2:0] indirect_instance_index,
  input rcps_pkg::rcps_byte_t ind_rdata,
  input logic ind_rvalid,
  input logic parity_even_sel,
  input logic wide_mode,
  input logic [7:0] entry_parity_err,
  input logic addr_load,
  input logic [31:0] addr_load_val,
  input logic addr_step,
  input logic [2:0] addr_chan,
  input logic [31:0] ring_addr,
  input logic entry_port_b,
  input logic data_port_b,
  input logic parity_odd
);
  import rcps_pkg::*;
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [7:0] par_seen_reg;
  // error vector one edge late, when the state flag has landed
  always_ff @(posedge core_clk) begin
    par_seen_reg <= nrst ? entry_parity_err : 8'h00;
  end
  sequence fault_rd;
    ind_rd && indirect_type_index == 4'hE && indirect_instance_index < 3'h6
      && par_seen_reg[indirect_instance_index];
  endsequence
  sequence step_req;
    addr_step && !addr_load && $stable(addr_chan);
  endsequence
  read_pulse_a: assert property ($past(nrst) |-> ind_rvalid == $past(ind_rd))
    else $error("read answer not one cycle after request");
  parity_mode_a: assert property ($past(nrst) |-> parity_odd == !$past(parity_even_sel))
    else $error("parity mode not following control bit");
  wide_port_a: assert property ($past(nrst) && $past(wide_mode) |-> !entry_port_b && !data_port_b)
    else $error("port b used in wide mode");
  // ring_addr trails the tracker by one register stage
  addr_load_a: assert property (addr_load |=> ##1 ring_addr == $past(addr_load_val, 2))
    else $error("ring address not loaded");
  addr_wrap_a: assert property (step_req |=> ##1 ring_addr[31:18] == $past(ring_addr[31:18])
    && (ring_addr - $past(ring_addr) == ($past(wide_mode, 2) ? 32'h8 : 32'h4)
    || ring_addr < $past(ring_addr))) else $error("ring address step wrong");
  ring_hi_a: assert property (ind_rd && indirect_type_index == 4'hE
    && indirect_instance_index[2:1] == 2'b11 |=> (ind_rdata & 8'hEF) == 8'h00)
    else $error("ring 6 or 7 state shows more than ready bit");
  cmd_mask_a: assert property (ind_rd && indirect_type_index == 4'h6
    && indirect_instance_index[2:1] == 2'b11 |=> (ind_rdata & 8'hAF) == 8'h00)
    else $error("command source byte has stray bits");
  par_flag_a: assert property (fault_rd |=> ind_rdata[6] && ind_rdata[1])
    else $error("parity fault not shown with empty");
endmodule
bind rcps_top rcps_props u_props (.core_clk, .nrst, .ind_rd, .indirect_type_index,
  .indirect_instance_index, .ind_rdata, .ind_rvalid, .parity_even_sel, .wide_mode,
  .entry_parity_err, .addr_load, .addr_load_val, .addr_step, .addr_chan, .ring_addr,
  .entry_port_b, .data_port_b, .parity_odd);

// ### rcps_mem_model.sv
`timescale 1ns/1ps
module rcps_mem_model (
  input logic core_clk,
  input logic fetch,
  input logic [2:0] fetch_ring,
  input logic corrupt,
  input logic frame_bad,
  input logic parity_odd,
  output logic [7:0] entry_read_done,
  output logic [7:0] entry_parity_err,
  output logic [7:0] entry_op_err
);
  logic [8:0] word;
  // entry byte with the parity bit stored under the current mode
  always_comb begin
    word[7:0] = 8'hA5 ^ {5'h00, fetch_ring};
    word[8] = ^word[7:0] ^ parity_odd ^ corrupt;
  end
  initial begin
    entry_read_done = 8'h00;
    entry_parity_err = 8'h00;
    entry_op_err = 8'h00;
  end
  // results come one edge after the fetch, as a real bus would answer
  always @(posedge core_clk) begin
    entry_read_done <= fetch ? 8'h01 << fetch_ring : 8'h00;
    entry_parity_err <= (fetch && ^word != parity_odd) ? 8'h01 << fetch_ring : 8'h00;
    entry_op_err <= (fetch && frame_bad) ? 8'h01 << fetch_ring : 8'h00;
  end
endmodule

// ### ring_channel_param_state_bench.sv
`timescale 1ns/1ps
module ring_channel_param_state_bench;
  import rcps_pkg::*;
  logic core_clk, nrst, ind_wr, ind_rd, parity_even_sel, wide_mode, addr_load, addr_step;
  logic xfer_is_cmd, local_base_load, fetch, corrupt, frame_bad, ind_rvalid, entry_port_b;
  logic entry_par_chk, data_port_b, data_par_chk, dest_data_port_b, local_port_b;
  logic local_par_chk, parity_odd, upper_half_a;
  logic [3:0] indirect_type_index;
  logic [2:0] indirect_instance_index, addr_chan, xfer_chan, fetch_ring;
  logic [7:0] ind_wdata, local_mode, entry_read_done, entry_parity_err, entry_op_err;
  logic [7:0] ev [0:7];
  logic [31:0] addr_load_val, local_base_in, ring_addr, local_base, local_bytes;
  rcps_byte_t ind_rdata;
  int miscompares = 0;
  int total_checks = 0;
  rcps_top dut (.core_clk, .nrst, .ind_wr, .ind_rd, .indirect_type_index,
    .indirect_instance_index, .ind_wdata, .ind_rdata, .ind_rvalid, .parity_even_sel,
    .wide_mode, .local_mode, .ring_define(ev[0]), .ring_ready_access(ev[1]),
    .ring_stop_evt(ev[2]), .ring_empty_evt(ev[3]), .ring_complete_evt(ev[4]),
    .entry_read_done, .entry_parity_err, .entry_op_err, .dest_ready_set(ev[5]),
    .dest_ready_clr(ev[6]), .ring_remove(ev[7]), .addr_chan, .addr_load, .addr_load_val,
    .addr_step, .xfer_chan, .xfer_is_cmd, .local_base_in, .local_base_load, .ring_addr,
    .entry_port_b, .entry_par_chk, .data_port_b, .data_par_chk, .dest_data_port_b,
    .local_port_b, .local_par_chk, .local_base, .local_bytes, .parity_odd, .upper_half_a);
  rcps_mem_model mem (.core_clk, .fetch, .fetch_ring, .corrupt, .frame_bad, .parity_odd,
    .entry_read_done, .entry_parity_err, .entry_op_err);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic complete_run;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  // register access: request held for one edge, then released
  task automatic wr(input logic [3:0] t, input logic [2:0] i, input logic [7:0] d);
    @(posedge core_clk);
    {ind_wr, indirect_type_index, indirect_instance_index, ind_wdata} <= {1'b1, t, i, d};
    @(posedge core_clk);
    ind_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] t, input logic [2:0] i, input logic [7:0] m,
    input logic [7:0] e, input string w);
    @(posedge core_clk);
    {ind_rd, indirect_type_index, indirect_instance_index} <= {1'b1, t, i};
    @(posedge core_clk);
    ind_rd <= 1'b0;
    #1;
    chk({23'h0, ind_rvalid, ind_rdata & m}, {23'h0, 1'b1, e}, w);
  endtask
  task automatic pulse(input int k, input logic [7:0] m);
    @(posedge core_clk);
    ev[k] <= m;
    @(posedge core_clk);
    ev[k] <= 8'h00;
  endtask
  task automatic get_entry(input logic c, input logic b);
    @(posedge core_clk);
    {fetch, fetch_ring, corrupt, frame_bad} <= {1'b1, 3'h1, c, b};
    @(posedge core_clk);
    fetch <= 1'b0;
  endtask
  task automatic steer(input logic [2:0] c, input logic cmd);
    @(posedge core_clk);
    {xfer_chan, xfer_is_cmd} <= {c, cmd};
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic addr(input logic ld, input logic [31:0] v, input logic [31:0] e);
    @(posedge core_clk);
    {addr_load, addr_step, addr_load_val} <= {ld, !ld, v};
    @(posedge core_clk);
    {addr_load, addr_step} <= 2'b00;
    // ring_addr is the tracker value one register stage later
    @(posedge core_clk);
    #1;
    chk(ring_addr, e, "ring address");
  endtask
  task automatic test_regs;
    rd(4'hE, 3'h0, 8'hFF, 8'h00, "state reset");
    wr(4'h6, 3'h0, 8'hF3);
    wr(4'h5, 3'h0, 8'h00);
    rd(4'h6, 3'h0, 8'hFF, 8'hF3, "ring params");
    wr(4'h6, 3'h6, 8'hFF);
    rd(4'h6, 3'h6, 8'hFF, 8'h50, "cmd mask");
    wr(4'h7, 3'h3, 8'hFF);
    rd(4'h7, 3'h3, 8'hFF, 8'hBF, "dest layout");
    wr(4'hE, 3'h0, 8'hFF);
    rd(4'hE, 3'h0, 8'hFF, 8'h00, "state read only");
    $display("test_regs done");
  endtask
  task automatic test_steer;
    wr(4'h6, 3'h2, 8'hF0);
    steer(3'h2, 1'b0);
    chk({28'h0, entry_port_b, entry_par_chk, data_port_b, data_par_chk}, 32'hF, "ring");
    wr(4'h6, 3'h2, 8'h00);
    steer(3'h2, 1'b0);
    chk({28'h0, entry_port_b, entry_par_chk, data_port_b, data_par_chk}, 32'h0, "ring a");
    wr(4'h6, 3'h7, 8'h50);
    steer(3'h7, 1'b1);
    chk({30'h0, data_port_b, data_par_chk}, 32'h3, "cmd steer");
    wr(4'h7, 3'h2, 8'h10);
    steer(3'h2, 1'b0);
    chk({31'h0, dest_data_port_b}, 32'h1, "dest port");
    @(posedge core_clk);
    {local_mode, parity_even_sel} <= {8'h04, 1'b1};
    for (int k = 0; k < 8; k++) begin
      wr(4'h7, 3'h2, 8'h50 | 8'(k));
      steer(3'h2, 1'b0);
      chk(local_bytes, 32'h2000 << k, "local size");
    end
    chk({29'h0, local_port_b, local_par_chk, parity_odd}, 32'h6, "local");
    {local_base_in, local_base_load} <= {32'h0008_0000, 1'b1};
    @(posedge core_clk);
    local_base_load <= 1'b0;
    wr(4'h7, 3'h2, 8'h51);
    steer(3'h2, 1'b0);
    chk(local_base, 32'h0008_0000, "local base");
    $display("test_steer done");
  endtask
  task automatic test_addr;
    wr(4'h6, 3'h0, 8'h03);
    addr(1'b1, 32'h0000_1BF8, 32'h0000_1BF8);
    addr(1'b0, 32'h0, 32'h0000_1BFC);
    addr(1'b0, 32'h0, 32'h0000_1BC0);
    wr(4'h6, 3'h0, 8'h0F);
    addr(1'b1, 32'h0003_FFFC, 32'h0003_FFFC);
    addr(1'b0, 32'h0, 32'h0000_0000);
    wr(4'h6, 3'h0, 8'hC3);
    wide_mode <= 1'b1;
    addr(1'b1, 32'h0000_1BF8, 32'h0000_1BF8);
    addr(1'b0, 32'h0, 32'h0000_1BC0);
    chk({30'h0, entry_port_b, upper_half_a}, 32'h1, "wide");
    wide_mode <= 1'b0;
    $display("test_addr done");
  endtask
  task automatic test_state;
    pulse(0, 8'h02);
    rd(4'hE, 3'h1, 8'h80, 8'h80, "present");
    get_entry(1'b1, 1'b0);
    rd(4'hE, 3'h1, 8'h46, 8'h42, "parity fault");
    pulse(1, 8'h02);
    rd(4'hE, 3'h1, 8'h6E, 8'h04, "ready");
    get_entry(1'b0, 1'b1);
    rd(4'hE, 3'h1, 8'h22, 8'h22, "op fault");
    pulse(4, 8'h02);
    rd(4'hE, 3'h1, 8'h0D, 8'h01, "complete");
    pulse(1, 8'h02);
    rd(4'hE, 3'h1, 8'h25, 8'h05, "ready complete");
    get_entry(1'b0, 1'b0);
    rd(4'hE, 3'h1, 8'h05, 8'h04, "cpl cleared");
    pulse(2, 8'h02);
    rd(4'hE, 3'h1, 8'h0C, 8'h08, "stop");
    pulse(1, 8'h02);
    pulse(3, 8'h02);
    rd(4'hE, 3'h1, 8'h0F, 8'h02, "empty");
    pulse(7, 8'h02);
    rd(4'hE, 3'h1, 8'h80, 8'h00, "removed");
    pulse(5, 8'h40);
    rd(4'hE, 3'h6, 8'hFF, 8'h10, "dest ready");
    pulse(6, 8'h40);
    rd(4'hE, 3'h6, 8'hFF, 8'h00, "dest idle");
    $display("test_state done");
  endtask
  // watchdog: tests need well under a thousand cycles
  initial begin
    #20000;
    miscompares++;
    complete_run();
  end
  initial begin
    {nrst, ind_wr, ind_rd, parity_even_sel, wide_mode, addr_load, addr_step} = 7'h00;
    {xfer_is_cmd, local_base_load, fetch, corrupt, frame_bad, local_mode} = 13'h0000;
    {indirect_type_index, indirect_instance_index, addr_chan, xfer_chan, fetch_ring} = 16'h0;
    {ind_wdata, addr_load_val, local_base_in} = 72'h0;
    foreach (ev[k]) ev[k] = 8'h00;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    test_regs();
    test_steer();
    test_addr();
    test_state();
    complete_run();
  end
endmodule
